// *** rtl/nipc_pkg.sv ***
package nipc_pkg;

  localparam int NUM_VEC = 14;
  localparam int NUM_PREG = 4;

  // Register byte offsets
  localparam logic [7:0] OFF_PRIO0 = 8'h00;
  localparam logic [7:0] OFF_PRIO1 = 8'h04;
  localparam logic [7:0] OFF_PRIO2 = 8'h08;
  localparam logic [7:0] OFF_PRIO3 = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  localparam logic [7:0] PRIO_RESET = 8'hFF;
  localparam logic [3:0] PRIO3_RO_ONES = 4'hF;
  localparam logic [7:0] CC_RESET = 8'hEA;
  localparam int CC_HI_BIT = 5;
  localparam int CC_LO_BIT = 3;
  localparam logic CTRL_RESET = 1'b1;

  // Priority bit pairs
  localparam logic [1:0] PAIR_L0 = 2'b10;
  localparam logic [1:0] PAIR_L1 = 2'b01;
  localparam logic [1:0] PAIR_L2 = 2'b00;
  localparam logic [1:0] PAIR_L3 = 2'b11;

  localparam logic [1:0] LVL0 = 2'h0;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h2;
  localparam logic [1:0] LVL3 = 2'h3;

  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_BASE = 16'hFFFA;
  localparam logic [3:0] VEC_TOP = 4'h0;
  localparam int VEC_CLK_TB = 1;
  localparam int VEC_CAN_TX = 7;

  // Halt wake capability per vector; bits 1 and 7 are qualified at run time
  localparam logic [13:0] HALT_WAKE_MASK = 14'h213D;

  typedef enum logic [6:0] {
    NIPC_IDLE = 7'b0000001,
    NIPC_PCL = 7'b0000010,
    NIPC_PCH = 7'b0000100,
    NIPC_X = 7'b0001000,
    NIPC_A = 7'b0010000,
    NIPC_CC = 7'b0100000,
    NIPC_VEC = 7'b1000000
  } nipc_state_t;

  typedef enum logic [2:0] {
    PUSH_NONE = 3'h0,
    PUSH_PCL = 3'h1,
    PUSH_PCH = 3'h2,
    PUSH_X = 3'h3,
    PUSH_A = 3'h4,
    PUSH_CC = 3'h5
  } nipc_push_t;

  typedef struct packed {
    logic instr_end;
    logic enable_irq_instr;
    logic disable_irq_instr;
    logic wait_for_irq_instr;
    logic halt_instr;
    logic pop_condition_code;
    logic irq_return_instr;
    logic trap_instr;
    logic [7:0] cc_data;
  } nipc_cpu_cmd_t;

  typedef struct packed {
    nipc_push_t push_sel;
    logic vec_load;
    logic [15:0] vec_addr;
    logic [13:0] svc_ack;
  } nipc_svc_t;

  function automatic logic [1:0] nipc_level(input logic [1:0] pair);
    logic [1:0] l;
    l = LVL0;
    case (pair)
      PAIR_L0: l = LVL0;
      PAIR_L1: l = LVL1;
      PAIR_L2: l = LVL2;
      default: l = LVL3;
    endcase
    return l;
  endfunction

endpackage

// *** rtl/nipc_prio_cell.sv ***
`timescale 1ns/1ps
module nipc_prio_cell
(
  // Vector side
  input wire logic [1:0] field,
  input wire logic req,
  // Current level
  input wire logic [1:0] cur_lvl,
  // Result
  output logic [1:0] lvl,
  output logic elig
);
  import nipc_pkg::*;

  assign lvl = nipc_level(field);
  assign elig = req && (lvl > cur_lvl);
endmodule

// *** rtl/nipc_ctrl.sv ***
`timescale 1ns/1ps
// Function
// - Any pending request wakes the core from wait mode.
// - After halt, first serviced vector must be halt-wake capable, normal arbitration.
// - Non-wake pending winner is serviced only after the first wake vector.
// - Concurrent mode lets only top-level preempt a routine; nested mode lets higher levels preempt.
// - Hardware order: main, then vector 13 up to 1, top-level highest.
// - No detection or signalling of stack overflow from deep nesting.
// - Current level sits in condition bits 5 and 3; reset value 111x 1010.
// - Pairs 10, 01, 00, 11 are levels 0 to 3; 3 masks all.
// - Top-level, trap and reset still accepted at level 3.
// - Entering a routine loads current level with the vector's stored pair.
// - Enable instruction loads 10, disable instruction loads 11.
// - Masked-jump taken when pair is 11, complementary jump otherwise.
// - Priority registers reset to ones; top four bits of last read one.
// - Each maskable vector owns one field, field 0 at FFFAh up to 13.
// - Top-level field is read/write but ignored by arbitration.
// - Writing the level 0 pair to a field leaves that field unchanged.
// - Reset, trap and top-level servicing set both level bits.
// - Raising a running vector's field while pending re-enters it.
// - Halt, pop, enable, disable, wait instructions alter level until next such.
// - Vector addresses reset FFFEh, trap FFFCh, then FFFAh downward by two.
// - Fixed halt-wake capability per vector; clock time base only in active halt.
// - CAN transmit vector wakes halt only on bus wake status change.
// - Maskable request served only if its level exceeds current; else pending.
// - Highest software level first, ties broken by hardware order.
// - Push PC, X, A and CC before loading the vector.
module nipc_ctrl
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources, already enabled at the peripheral
  input wire logic [13:0] irq_src,
  input wire logic active_halt,
  input wire logic can_wake_sc,
  // CPU sequencer
  input wire nipc_pkg::nipc_cpu_cmd_t cpu_cmd,
  output nipc_pkg::nipc_svc_t svc,
  output logic irq_pending,
  output logic [7:0] cc,
  output logic jump_if_masked,
  output logic jump_if_not_masked,
  output logic in_halt,
  output logic in_wait
);
  import nipc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] vector_priority_regs [NUM_PREG];
  logic nested_mode;
  logic [7:0] depth;
  logic halt_first;
  nipc_state_t state;
  logic [3:0] svc_vec;
  logic svc_top;
  // Trap kept apart: its vector index is whatever arbitration showed
  logic svc_trap;
  logic [1:0] cur_pair;
  logic [1:0] cur_lvl;
  logic [1:0] lvl [NUM_VEC];
  logic [13:0] elig;
  logic [13:0] wake_cap;
  logic [13:0] allow;
  logic sel_ok;
  logic [3:0] sel_idx;
  logic [1:0] best_lvl;
  logic start;
  logic [1:0] svc_field;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [7:0] off;

  assign cur_pair = {cc[CC_HI_BIT], cc[CC_LO_BIT]};
  assign cur_lvl = nipc_level(cur_pair);
  assign jump_if_masked = (cur_pair == PAIR_L3);
  assign jump_if_not_masked = (cur_pair != PAIR_L3);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, read data caught in setup
  assign off = paddr[7:0];
  assign addr_ok = (paddr[31:8] == 24'h000000) && (off[1:0] == 2'b00)
    && (off <= OFF_STATUS);
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_setup)
    begin
      prdata <= 32'h00000000;
      unique case (off)
        OFF_PRIO0: prdata[7:0] <= vector_priority_regs[0];
        OFF_PRIO1: prdata[7:0] <= vector_priority_regs[1];
        OFF_PRIO2: prdata[7:0] <= vector_priority_regs[2];
        OFF_PRIO3: prdata[7:0] <= vector_priority_regs[3];
        OFF_CTRL: prdata[0] <= nested_mode;
        OFF_STATUS: prdata <= {8'h00, depth, 3'h0, halt_first, svc_vec, cc};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Field writes of the level 0 pair are dropped one field at a time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int r = 0; r < NUM_PREG; r++)
        vector_priority_regs[r] <= PRIO_RESET;
    end
    else if (wr_en && pstrb[0] && (off < OFF_CTRL))
    begin
      for (int f = 0; f < 4; f++)
      begin
        if (pwdata[2*f +: 2] != PAIR_L0)
          vector_priority_regs[off[3:2]][2*f +: 2] <= pwdata[2*f +: 2];
      end
      if (off == OFF_PRIO3)
        vector_priority_regs[3][7:4] <= PRIO3_RO_ONES;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nested_mode <= CTRL_RESET;
    else if (wr_en && pstrb[0] && (off == OFF_CTRL))
      nested_mode <= pwdata[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-vector level compare
  for (genvar v = 0; v < NUM_VEC; v++)
  begin : g_cell
    nipc_prio_cell u_cell
    (
      .field(vector_priority_regs[v / 4][2*(v % 4) +: 2]),
      .req(irq_src[v]),
      .cur_lvl(cur_lvl),
      .lvl(lvl[v]),
      .elig(elig[v])
    );
  end

  // Clock time base and CAN status change wake only when qualified
  always_comb
  begin
    wake_cap = HALT_WAKE_MASK;
    wake_cap[VEC_CLK_TB] = active_halt;
    wake_cap[VEC_CAN_TX] = can_wake_sc;
  end

  always_comb
  begin
    allow = 14'h3FFF;
    if (in_halt || halt_first)
      allow = wake_cap;
    if (!nested_mode && (depth != 8'h00))
      allow[13:1] = 13'h0000;
  end

  // Higher level wins; scanning downward from 13 to 1 lets lower numbers win ties
  always_comb
  begin
    sel_ok = 1'b0;
    sel_idx = 4'h0;
    best_lvl = LVL0;
    for (int i = NUM_VEC - 1; i >= 1; i--)
    begin
      if (elig[i] && allow[i] && (!sel_ok || (lvl[i] >= best_lvl)))
      begin
        sel_ok = 1'b1;
        sel_idx = 4'(i);
        best_lvl = lvl[i];
      end
    end
    // Top-level ignores its field and the current level
    if (irq_src[0] && allow[0])
    begin
      sel_ok = 1'b1;
      sel_idx = VEC_TOP;
    end
  end

  assign irq_pending = sel_ok && (state == NIPC_IDLE);
  assign start = (state == NIPC_IDLE)
    && (cpu_cmd.trap_instr || (cpu_cmd.instr_end && sel_ok));

  ////////////////////////////////////////////////////////////////////////////
  // Entry sequence
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= NIPC_IDLE;
    else
    begin
      unique case (state)
        NIPC_IDLE: if (start) state <= NIPC_PCL;
        NIPC_PCL: state <= NIPC_PCH;
        NIPC_PCH: state <= NIPC_X;
        NIPC_X: state <= NIPC_A;
        NIPC_A: state <= NIPC_CC;
        NIPC_CC: state <= NIPC_VEC;
        NIPC_VEC: state <= NIPC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      svc_vec <= 4'h0;
      svc_top <= 1'b0;
      svc_trap <= 1'b0;
    end
    else if (start)
    begin
      svc_vec <= sel_idx;
      svc_top <= cpu_cmd.trap_instr || (sel_idx == VEC_TOP);
      svc_trap <= cpu_cmd.trap_instr;
    end
  end

  // Field read at entry so a raised field is what gets loaded
  assign svc_field = vector_priority_regs[svc_vec[3:2]][2*svc_vec[1:0] +: 2];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      svc <= '0;
    else
    begin
      svc.vec_load <= (state == NIPC_CC);
      svc.svc_ack <= 14'h0000;
      unique case (state)
        NIPC_IDLE: svc.push_sel <= start ? PUSH_PCL : PUSH_NONE;
        NIPC_PCL: svc.push_sel <= PUSH_PCH;
        NIPC_PCH: svc.push_sel <= PUSH_X;
        NIPC_X: svc.push_sel <= PUSH_A;
        NIPC_A: svc.push_sel <= PUSH_CC;
        NIPC_CC: svc.push_sel <= PUSH_NONE;
        NIPC_VEC: svc.push_sel <= PUSH_NONE;
      endcase
      if (state == NIPC_CC)
      begin
        if (svc_trap)
          svc.vec_addr <= VEC_TRAP;
        else
          svc.vec_addr <= VEC_BASE - {11'h000, svc_vec, 1'b0};
        if (!svc_trap)
          svc.svc_ack[svc_vec] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition code; entry load wins over instructions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cc <= CC_RESET;
    else if (state == NIPC_VEC)
    begin
      if (svc_top)
        {cc[CC_HI_BIT], cc[CC_LO_BIT]} <= PAIR_L3;
      else
        {cc[CC_HI_BIT], cc[CC_LO_BIT]} <= svc_field;
    end
    else if (cpu_cmd.irq_return_instr || cpu_cmd.pop_condition_code)
      cc <= cpu_cmd.cc_data;
    else if (cpu_cmd.disable_irq_instr)
      {cc[CC_HI_BIT], cc[CC_LO_BIT]} <= PAIR_L3;
    else if (cpu_cmd.enable_irq_instr || cpu_cmd.halt_instr
      || cpu_cmd.wait_for_irq_instr)
      {cc[CC_HI_BIT], cc[CC_LO_BIT]} <= PAIR_L0;
  end

  // Nesting depth saturates silently; stack overflow goes unnoticed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      depth <= 8'h00;
    else if ((state == NIPC_VEC) && (depth != 8'hFF))
      depth <= depth + 8'h01;
    else if (cpu_cmd.irq_return_instr && (depth != 8'h00))
      depth <= depth - 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low power tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_wait <= 1'b0;
    else if (|irq_src)
      in_wait <= 1'b0;
    else if (cpu_cmd.wait_for_irq_instr)
      in_wait <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_halt <= 1'b0;
      halt_first <= 1'b0;
    end
    else if (in_halt && |(irq_src & wake_cap))
    begin
      in_halt <= 1'b0;
      halt_first <= 1'b1;
    end
    else if (cpu_cmd.halt_instr)
      in_halt <= 1'b1;
    else if (state == NIPC_VEC)
      halt_first <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_WAIT_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (in_wait && |irq_src) |=> !in_wait)
    else $error("wait not left on request");

  AST_HALT_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    (start && halt_first && !cpu_cmd.trap_instr) |-> wake_cap[sel_idx])
    else $error("first vector after halt not wake capable");

  AST_CONCURRENT: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !nested_mode && (depth != 8'h00) && !cpu_cmd.trap_instr)
    |-> (sel_idx == VEC_TOP))
    else $error("routine preempted in concurrent mode");

  AST_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !cpu_cmd.trap_instr && (sel_idx != VEC_TOP))
    |-> (lvl[sel_idx] > cur_lvl))
    else $error("vector taken at or below current level");

  AST_ENTRY_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    ((state == NIPC_VEC) && !svc_top)
    |=> ({cc[CC_HI_BIT], cc[CC_LO_BIT]} == $past(svc_field)))
    else $error("entry level not loaded from field");

  AST_TOP_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    ((state == NIPC_VEC) && svc_top) |=> jump_if_masked)
    else $error("trap or top-level entry left level below 3");

  AST_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_cmd.enable_irq_instr && (state != NIPC_VEC)
    && !cpu_cmd.disable_irq_instr && !cpu_cmd.irq_return_instr
    && !cpu_cmd.pop_condition_code) |=> (cur_lvl == LVL0))
    else $error("enable did not set level 0");

  AST_DISABLE: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_cmd.disable_irq_instr && (state != NIPC_VEC)
    && !cpu_cmd.irq_return_instr && !cpu_cmd.pop_condition_code)
    |=> (cur_lvl == LVL3) && jump_if_masked && !jump_if_not_masked)
    else $error("disable did not set level 3");

  AST_ZERO_PAIR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && pstrb[0] && (off == OFF_PRIO0) && (pwdata[5:4] == PAIR_L0))
    |=> (vector_priority_regs[0][5:4]
    == $past(vector_priority_regs[0][5:4])))
    else $error("level 0 pair was written");

  AST_RO_TOP: assert property (@(posedge pclk) disable iff (!presetn)
    vector_priority_regs[3][7:4] == PRIO3_RO_ONES)
    else $error("read-only bits changed");

  AST_SEQUENCE: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> (state == NIPC_PCL) ##1 (state == NIPC_PCH)
    ##1 (state == NIPC_X) ##1 (state == NIPC_A) ##1 (state == NIPC_CC)
    ##1 ((state == NIPC_VEC) && svc.vec_load))
    else $error("entry sequence out of order");

endmodule

// *** dv/nipc_cpu_model.sv ***
`timescale 1ns/1ps
module nipc_cpu_model
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller side
  input wire nipc_pkg::nipc_svc_t svc,
  input wire logic in_halt,
  input wire logic in_wait,
  // Bench side
  input wire logic [13:0] set_req,
  output logic [13:0] irq_src,
  output logic instr_end,
  output logic [7:0] push_err
);
  import nipc_pkg::*;

  logic [2:0] next_push;

  // Sources hold a request until the controller acknowledges it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_src <= '0;
    else
      irq_src <= (irq_src | set_req) & ~svc.svc_ack;

  // Core retires nothing while asleep or while stacking
  assign instr_end = !in_halt && !in_wait && !svc.vec_load &&
                     (svc.push_sel == PUSH_NONE);

  ////////////////////////////////////////////////////////////////////////
  // Stacking order seen by the core
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      next_push <= 3'h1;
      push_err <= 8'h00;
    end
    else if (svc.push_sel != PUSH_NONE)
    begin
      if (svc.push_sel != next_push)
        push_err <= push_err + 8'h01;
      next_push <= next_push + 3'h1;
    end
    else if (svc.vec_load)
    begin
      // Vector fetched before all four registers are saved
      if (next_push != 3'h6)
        push_err <= push_err + 8'h01;
      next_push <= 3'h1;
    end
endmodule

// *** dv/tb_nested_interrupt_priority_ctrl.sv ***
`timescale 1ns/1ps
module tb_nested_interrupt_priority_ctrl;
  import nipc_pkg::*;

  localparam logic [7:0] OP_EN = 8'h40;
  localparam logic [7:0] OP_DIS = 8'h20;
  localparam logic [7:0] OP_WFI = 8'h10;
  localparam logic [7:0] OP_HALT = 8'h08;
  localparam logic [7:0] OP_POP = 8'h04;
  localparam logic [7:0] OP_IRQ_RETURN_INSTR = 8'h02;
  localparam logic [7:0] OP_TRAP = 8'h01;

  logic pclk = 1'b0;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, slv_err;
  logic [31:0] paddr, pwdata, prdata;
  logic [13:0] irq_src, set_req;
  logic instr_end, irq_pending, in_halt, in_wait;
  logic jump_if_masked, jump_if_not_masked;
  logic [7:0] cc, push_err;
  nipc_cpu_cmd_t cmd_tb, cpu_cmd;
  nipc_svc_t svc;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic act_halt = 1'b0;
  logic can_sc = 1'b0;

  always #50 pclk = ~pclk;

  always_comb
  begin
    cpu_cmd = cmd_tb;
    cpu_cmd.instr_end = instr_end;
  end

  nipc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_src(irq_src), .active_halt(act_halt), .can_wake_sc(can_sc),
    .cpu_cmd(cpu_cmd), .svc(svc), .irq_pending(irq_pending), .cc(cc),
    .jump_if_masked(jump_if_masked),
    .jump_if_not_masked(jump_if_not_masked),
    .in_halt(in_halt), .in_wait(in_wait));

  nipc_cpu_model u_model (.pclk(pclk), .presetn(presetn), .svc(svc),
    .in_halt(in_halt), .in_wait(in_wait), .set_req(set_req),
    .irq_src(irq_src), .instr_end(instr_end), .push_err(push_err));

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Ceiling well above the roughly 400 cycles the tests need
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h00000000, r);
    check(r, exp);
  endtask

  task automatic instr(input logic [7:0] op, input logic [7:0] cd);
    @(posedge pclk);
    cmd_tb <= {1'b0, op[6:0], cd};
    @(posedge pclk);
    cmd_tb <= '0;
    @(negedge pclk);
  endtask

  task automatic raise(input logic [13:0] m);
    @(posedge pclk);
    set_req <= m;
    @(posedge pclk);
    set_req <= '0;
  endtask

  // Waits for a vector fetch, then lets the level load land
  task automatic wait_ack(input logic [13:0] ack, input logic [15:0] va);
    while (svc.vec_load !== 1'b1)
      @(negedge pclk);
    check({18'h00000, svc.svc_ack}, {18'h00000, ack});
    check({16'h0000, svc.vec_addr}, {16'h0000, va});
    repeat (2) @(negedge pclk);
  endtask

  function automatic logic [31:0] pair();
    return {30'h00000000, cc[5], cc[3]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({24'h000000, cc}, 32'h000000EA);
    check({31'h0, jump_if_masked}, 32'h00000001);
    for (int i = 0; i < 4; i++)
      rchk(OFF_PRIO0 + 8'(4 * i), 32'h000000FF);
    $display("test reset done");
  endtask

  task automatic t_regs();
    wr(OFF_PRIO0, 32'h000000CF);
    wr(OFF_PRIO0, 32'h00000064);
    rchk(OFF_PRIO0, 32'h00000044);
    wr(OFF_PRIO3, 32'h00000000);
    rchk(OFF_PRIO3, 32'h000000F0);
    wr(OFF_PRIO3, 32'h000000FF);
    rchk(8'h18, 32'h00000000);
    check({31'h0, slv_err}, 32'h00000001);
    $display("test regs done");
  endtask

  task automatic t_instr();
    instr(OP_EN, 8'h00);
    check(pair(), {30'h0, PAIR_L0});
    check({31'h0, jump_if_not_masked}, 32'h00000001);
    instr(OP_DIS, 8'h00);
    check(pair(), {30'h0, PAIR_L3});
    check({31'h0, jump_if_masked}, 32'h00000001);
    instr(OP_POP, 8'h00);
    check({24'h000000, cc}, 32'h00000000);
    check({31'h0, jump_if_masked}, 32'h00000000);
    $display("test instr done");
  endtask

  task automatic t_entry();
    wr(OFF_PRIO1, 32'h000000F7);
    instr(OP_DIS, 8'h00);
    raise(14'h0020);
    repeat (4) @(negedge pclk);
    check({31'h0, irq_pending}, 32'h00000000);
    instr(OP_EN, 8'h00);
    wait_ack(14'h0020, 16'hFFF0);
    check(pair(), {30'h0, PAIR_L1});
    raise(14'h0020);
    wr(OFF_PRIO1, 32'h000000F3);
    wait_ack(14'h0020, 16'hFFF0);
    check(pair(), {30'h0, PAIR_L2});
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    $display("test entry done");
  endtask

  task automatic t_order();
    wr(OFF_PRIO1, 32'h000000FD);
    wr(OFF_PRIO2, 32'h000000F7);
    instr(OP_DIS, 8'h00);
    raise(14'h0210);
    instr(OP_EN, 8'h00);
    wait_ack(14'h0010, 16'hFFF2);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    wait_ack(14'h0200, 16'hFFE8);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    wr(OFF_PRIO2, 32'h000000FF);
    instr(OP_DIS, 8'h00);
    raise(14'h0210);
    instr(OP_EN, 8'h00);
    wait_ack(14'h0200, 16'hFFE8);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    wait_ack(14'h0010, 16'hFFF2);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    $display("test order done");
  endtask

  task automatic t_top();
    instr(OP_DIS, 8'h00);
    instr(OP_TRAP, 8'h00);
    wait_ack(14'h0000, 16'hFFFC);
    check(pair(), {30'h0, PAIR_L3});
    raise(14'h0001);
    wait_ack(14'h0001, 16'hFFFA);
    check(pair(), {30'h0, PAIR_L3});
    instr(OP_IRQ_RETURN_INSTR, 8'hEA);
    instr(OP_IRQ_RETURN_INSTR, 8'hEA);
    check({24'h000000, push_err}, 32'h00000000);
    $display("test top done");
  endtask

  task automatic t_halt();
    wr(OFF_PRIO2, 32'h000000F3);
    wr(OFF_PRIO3, 32'h000000F7);
    instr(OP_HALT, 8'h00);
    check(pair(), {30'h0, PAIR_L0});
    raise(14'h0202);
    repeat (10) @(negedge pclk);
    check({31'h0, in_halt}, 32'h00000001);
    raise(14'h2000);
    wait_ack(14'h2000, 16'hFFE0);
    wait_ack(14'h0200, 16'hFFE8);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    wait_ack(14'h0002, 16'hFFF8);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    instr(OP_HALT, 8'h00);
    raise(14'h0080);
    repeat (4) @(negedge pclk);
    check({31'h0, in_halt}, 32'h00000001);
    @(posedge pclk);
    can_sc <= 1'b1;
    wait_ack(14'h0080, 16'hFFEC);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    @(posedge pclk);
    act_halt <= 1'b1;
    instr(OP_HALT, 8'h00);
    raise(14'h0002);
    wait_ack(14'h0002, 16'hFFF8);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    $display("test halt done");
  endtask

  task automatic t_wait();
    instr(OP_WFI, 8'h00);
    check({31'h0, in_wait}, 32'h00000001);
    raise(14'h0400);
    wait_ack(14'h0400, 16'hFFE6);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    $display("test wait done");
  endtask

  task automatic t_conc();
    wr(OFF_CTRL, 32'h00000000);
    wr(OFF_PRIO1, 32'h000000DD);
    instr(OP_EN, 8'h00);
    raise(14'h0040);
    wait_ack(14'h0040, 16'hFFEE);
    raise(14'h0100);
    repeat (20) @(negedge pclk);
    check({31'h0, irq_pending}, 32'h00000000);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    wait_ack(14'h0100, 16'hFFEA);
    instr(OP_IRQ_RETURN_INSTR, 8'hE2);
    wr(OFF_CTRL, 32'h00000001);
    $display("test concurrent done");
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    set_req = '0;
    cmd_tb = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_regs();
    t_instr();
    t_entry();
    t_order();
    t_top();
    t_halt();
    t_wait();
    t_conc();
    report_and_stop();
  end
endmodule
